/* File: sdc_decoder.sv */
// Sub-audio digital code decoder: filter, slicer, bit timing, correlator, turn-off tone.
`timescale 1ns/100ps

// Notes on behaviour
// - Input is NRZ at 134.4 bit/s; timing realigns on every edge to absorb drift.
// - Any programmed code of 23 or 24 bits, length picked by configuration.
// - Mode A: positive shift is one; mode B inverts the mapping.
// - Received bits are compared only against the programmed code words.
// - First received bit is matched to code bit 0, last to the top bit.
// - Match is declared when three or fewer bit positions differ.
// - Flag reads zero after any evaluation at which the match condition fails.
// - Flag is re-evaluated once after every fourth received bit.
// - Turn-off tone is 134.4 Hz within 0.5 Hz lasting 150 to 200 ms; the detector fires once 150 ms is reached and checks no upper limit.
// - Detected turn-off tone with option set raises the squelch interrupt.
// - Signal is low-pass filtered, equalised, sliced and level detected first.
// - Code held as upper field bits 23..12 and lower field bits 11..0.
module sdc_decoder #(
   parameter int SAMPLE_W   = 12,
   parameter int BIT_CYCLES = sdc_pkg::BIT_CYCLES,
   parameter int HALF_MIN   = sdc_pkg::TONE_HALF_MIN,
   parameter int HALF_MAX   = sdc_pkg::TONE_HALF_MAX,
   parameter int FIFO_DEPTH = sdc_pkg::FIFO_DEPTH
) (
   input  wire logic                       ref_clk,
   input  wire logic                       resetn,
   input  wire logic signed [SAMPLE_W-1:0] disc_sample,
   input  wire logic                       sample_valid,
   input  wire logic        [SAMPLE_W-1:0] level_threshold,
   input  wire logic                       polarity_invert,
   input  wire logic                       code_len_24,
   input  wire logic        [11:0]         code_upper,
   input  wire logic        [11:0]         code_lower,
   input  wire logic                       turnoff_enable,
   output logic                            code_detected,
   output logic                            turnoff_irq,
   output logic                            signal_present
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Widths and elaboration checks

   localparam int CB     = sdc_pkg::CODE_MAX_BITS;
   localparam int FB     = sdc_pkg::FIELD_BITS;
   localparam int LW     = SAMPLE_W + 2;
   localparam int EW     = LW + sdc_pkg::EQ_SHIFT + 1;
   localparam int PW     = $clog2(BIT_CYCLES);
   localparam int HALF_BIT = BIT_CYCLES / 2;
   localparam int NW     = $clog2(CB + 1);
   localparam int QW     = $clog2(sdc_pkg::FLAG_EVERY);

   if (SAMPLE_W < 4 || BIT_CYCLES < 4 || FIFO_DEPTH < 2)
   begin : g_bad
      $error("sdc_decoder parameters out of range");
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Front end: low pass, equaliser, slicer, level detector

   logic signed [LW-1:0] lpf;
   logic signed [LW-1:0] lpf_prev;
   logic signed [EW-1:0] env;
   logic                 sliced;
   logic                 sliced_prev;
   logic                 slice_edge;

   wire signed [LW-1:0] x_ext     = LW'(disc_sample);
   wire signed [LW-1:0] lpf_step  = (x_ext - lpf) >>> sdc_pkg::LPF_SHIFT;
   wire signed [LW-1:0] next_lpf  = lpf + lpf_step;
   // Boost of the slope restores edges dulled by the low pass
   wire signed [EW-1:0] slope     = EW'(lpf) - EW'(lpf_prev);
   wire signed [EW-1:0] eq_out    = EW'(lpf) + (slope <<< sdc_pkg::EQ_SHIFT);
   wire signed [EW-1:0] eq_mag    = eq_out[EW-1] ? -eq_out : eq_out;
   wire signed [EW-1:0] env_step  = (eq_mag - env) >>> sdc_pkg::ENV_SHIFT;
   wire signed [EW-1:0] next_env  = env + env_step;
   wire signed [EW-1:0] thr_ext   = EW'({1'b0, level_threshold});
   wire signed [EW-1:0] hyst      = thr_ext >>> sdc_pkg::HYST_SHIFT;
   wire                 above     = eq_out > hyst;
   wire                 below     = eq_out < -hyst;

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         lpf      <= '0;
         lpf_prev <= '0;
         env      <= '0;
      end
      else if (sample_valid)
      begin
         lpf      <= next_lpf;
         lpf_prev <= lpf;
         env      <= next_env;
      end
   end

   // Hysteresis keeps noise near zero from chattering the slicer
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         sliced         <= 1'b0;
         signal_present <= 1'b0;
      end
      else if (sample_valid)
      begin
         if (above)
         begin
            sliced <= 1'b1;
         end
         else if (below)
         begin
            sliced <= 1'b0;
         end
         signal_present <= env > thr_ext;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         sliced_prev <= 1'b0;
         slice_edge  <= 1'b0;
      end
      else
      begin
         sliced_prev <= sliced;
         slice_edge  <= sliced != sliced_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bit timing: a free running bit phase that snaps to every data edge

   logic [PW-1:0] phase;
   logic          pend_valid;
   logic          pend_bit;
   logic          fifo_in_ready;

   wire           phase_wrap   = (phase == PW'(BIT_CYCLES - 1));
   wire           sample_point = (phase == PW'(HALF_BIT)) && signal_present;
   // Mode B carries inverted data
   wire           rx_bit       = sliced ^ polarity_invert;

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         phase <= '0;
      end
      else if (slice_edge || phase_wrap)
      begin
         phase <= '0;
      end
      else
      begin
         phase <= phase + 1'b1;
      end
   end

   // A held bit waits while the FIFO is full; a newer bit replaces it
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         pend_valid <= 1'b0;
         pend_bit   <= 1'b0;
      end
      else if (sample_point)
      begin
         pend_valid <= 1'b1;
         pend_bit   <= rx_bit;
      end
      else if (fifo_in_ready)
      begin
         pend_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Bit buffer between bit recovery and the correlator

   logic fifo_out_valid;
   logic fifo_out_ready;
   logic fifo_out_bit;

   sdc_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .in_valid  (pend_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (pend_bit),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_bit)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Correlator

   logic [CB-1:0] history;
   logic [NW-1:0] fill;
   logic [QW-1:0] quad;
   logic          eval_pend;

   wire  [NW-1:0] code_len   = code_len_24 ? NW'(CB) : NW'(sdc_pkg::CODE_SHORT_BITS);
   wire  [CB-1:0] code_word  = {code_upper, code_lower};
   wire  [CB-1:0] len_mask   = {code_len_24, {(CB - 1){1'b1}}};
   wire           take_bit   = fifo_out_valid && fifo_out_ready;
   wire           window_full = (fill == code_len);
   // New bits enter at the top of the active window so the oldest sits at bit 0
   wire  [CB-1:0] shift_24   = {fifo_out_bit, history[CB-1:1]};
   wire  [CB-1:0] shift_23   = {1'b0, fifo_out_bit, history[CB-2:1]};
   wire  [CB-1:0] next_history = code_len_24 ? shift_24 : shift_23;
   wire  [CB-1:0] mismatch;

   // Stall intake for the evaluation cycle so the window stays frozen
   assign fifo_out_ready = !eval_pend;

   for (genvar i = 0; i < CB; i++)
   begin : g_cmp
      assign mismatch[i] = (history[i] ^ code_word[i]) & len_mask[i];
   end

   function automatic logic [NW-1:0] count_ones(input logic [CB-1:0] v);
      logic [NW-1:0] n;
      n = '0;
      for (int k = 0; k < CB; k++)
      begin
         n = n + NW'(v[k]);
      end
      return n;
   endfunction

   wire [NW-1:0] errors   = count_ones(mismatch);
   wire          matched  = window_full && (errors <= NW'(sdc_pkg::MAX_ERRORS));

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         history <= '0;
         fill    <= '0;
      end
      else if (take_bit)
      begin
         history <= next_history;
         if (!window_full)
         begin
            fill <= fill + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         quad      <= '0;
         eval_pend <= 1'b0;
      end
      else if (take_bit)
      begin
         quad      <= quad + 1'b1;
         eval_pend <= (quad == QW'(sdc_pkg::FLAG_EVERY - 1));
      end
      else
      begin
         eval_pend <= 1'b0;
      end
   end

   // Flag only moves in the evaluation cycle and holds otherwise
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         code_detected <= 1'b0;
      end
      else if (eval_pend)
      begin
         code_detected <= matched;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Turn-off tone: the slicer toggles every half period of the tone

   logic tone_event;

   sdc_tone_det #(
      .HALF_MIN (HALF_MIN),
      .HALF_MAX (HALF_MAX),
      .HALVES   (sdc_pkg::TONE_MIN_HALVES)
   ) u_tone (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .edge_seen  (slice_edge),
      .enable     (turnoff_enable),
      .tone_event (tone_event)
   );

   // Audio is never muted here; the host acts on this pulse
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         turnoff_irq <= 1'b0;
      end
      else
      begin
         turnoff_irq <= tone_event;
      end
   end

endmodule

/* File: sdc_decoder_asserts.sv */
// Port-level assertions for the sub-audio digital code decoder.
`timescale 1ns/100ps
module sdc_decoder_asserts #(
   parameter int BIT_CYCLES = sdc_pkg::BIT_CYCLES,
   parameter int HALF_MIN   = sdc_pkg::TONE_HALF_MIN
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sample_valid,
   input wire logic turnoff_enable,
   input wire logic code_detected,
   input wire logic turnoff_irq,
   input wire logic signal_present
);
   localparam int IRQ_GAP = sdc_pkg::TONE_MIN_HALVES * HALF_MIN;
   logic      [23:0] since_rst;
   logic      [23:0] since_flag;
   logic      [23:0] since_irq;
   logic             prev_flag;
   wire logic        flag_moved      = code_detected != prev_flag;
   wire logic [23:0] next_since_rst  = since_rst + {23'h0, ~&since_rst};
   wire logic [23:0] next_since_flag = flag_moved ? 24'h0 : since_flag + {23'h0, ~&since_flag};
   wire logic [23:0] next_since_irq  = turnoff_irq ? 24'h0 : since_irq + {23'h0, ~&since_irq};
   always_ff @(posedge ref_clk)
   begin
      prev_flag  <= resetn & code_detected;
      since_rst  <= resetn ? next_since_rst : 24'h0;
      since_flag <= resetn ? next_since_flag : 24'h0;
      since_irq  <= resetn ? next_since_irq : 24'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_reset_clears: assert property ($rose(resetn) |-> !code_detected && !turnoff_irq)
      else $error("Outputs not cleared by reset");
   // Four bits take at least two bit periods even with edge realignment
   a_flag_spacing: assert property (flag_moved |-> since_flag >= 2 * BIT_CYCLES)
      else $error("Code flag changed too soon after last update");
   a_flag_early: assert property ($rose(code_detected) |-> since_rst >= 16 * BIT_CYCLES)
      else $error("Code flag set before history refilled");
   a_irq_single: assert property (turnoff_irq |=> !turnoff_irq)
      else $error("Turn-off pulse longer than one cycle");
   a_irq_enable: assert property (turnoff_irq |-> $past(turnoff_enable, 2))
      else $error("Turn-off pulse without enable");
   a_irq_off: assert property (!turnoff_enable [*3] |=> !turnoff_irq)
      else $error("Turn-off pulse while disabled");
   a_irq_spacing: assert property (turnoff_irq |-> since_irq >= IRQ_GAP)
      else $error("Turn-off pulse before least tone length");
   a_present_sample: assert property ($changed(signal_present) && $past(resetn)
                                      |-> $past(sample_valid))
      else $error("Level flag moved without a sample");
   c_flag: cover property ($rose(code_detected));
   c_irq: cover property (turnoff_irq);
   c_present: cover property ($rose(signal_present));
endmodule

/* File: sdc_decoder_bench.sv */
// Self-checking bench for the sub-audio digital code decoder.
`timescale 1ns/100ps
module sdc_decoder_bench;
   localparam int BC   = 160;
   localparam int HMIN = 72;
   localparam int HMAX = 88;
   logic                ref_clk         = 1'b0;
   logic                resetn          = 1'b0;
   logic signed [11:0]  disc_sample;
   logic                sample_valid;
   logic        [11:0]  level_threshold = 12'h0C8;
   logic                polarity_invert = 1'b0;
   logic                code_len_24     = 1'b0;
   logic        [11:0]  code_upper      = 12'h000;
   logic        [11:0]  code_lower      = 12'h000;
   logic                turnoff_enable  = 1'b0;
   logic                code_detected;
   logic                turnoff_irq;
   logic                signal_present;
   logic        [1:0]   mode            = 2'h0;
   logic        [24:0]  pattern         = 25'h0000000;
   logic        [4:0]   pat_len         = 5'h17;
   logic                mode_b          = 1'b0;
   logic        [31:0]  seed            = 32'hD65FFC1A;
   int                  n_fail          = 0;
   int                  n_checks        = 0;
   always #50 ref_clk = ~ref_clk;
   sdc_decoder #(.BIT_CYCLES(BC), .HALF_MIN(HMIN), .HALF_MAX(HMAX)) i_sdc_decoder (
      .ref_clk        (ref_clk),
      .resetn         (resetn),
      .disc_sample    (disc_sample),
      .sample_valid   (sample_valid),
      .level_threshold(level_threshold),
      .polarity_invert(polarity_invert),
      .code_len_24    (code_len_24),
      .code_upper     (code_upper),
      .code_lower     (code_lower),
      .turnoff_enable (turnoff_enable),
      .code_detected  (code_detected),
      .turnoff_irq    (turnoff_irq),
      .signal_present (signal_present)
   );
   sdc_fm_source #(.BIT_CYCLES(BC), .HALF((HMIN + HMAX) / 2)) i_sdc_fm_source (
      .ref_clk     (ref_clk),
      .mode        (mode),
      .pattern     (pattern),
      .pat_len     (pat_len),
      .mode_b      (mode_b),
      .disc_sample (disc_sample),
      .sample_valid(sample_valid)
   );
   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic expect_hit(input logic [23:0] tx, input logic [23:0] prog,
                                       input int len);
      int errs;
      errs = 0;
      for (int i = 0; i < len; i++)
         errs += int'(tx[i] != prog[i]);
      return errs <= 3;
   endfunction
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      @(negedge ref_clk);
      check({21'h0, code_detected, turnoff_irq, signal_present}, 24'h0);
   endtask
   // A repeating stream realigns with the flag cadence only every few code periods
   task automatic run_code(input logic [23:0] tx, input logic [23:0] prog, input logic l24,
                           input logic inv, input int max_bits);
      logic seen;
      logic want;
      seen = 1'b0;
      want = expect_hit(tx, prog, l24 ? 24 : 23);
      do_reset();
      @(posedge ref_clk);
      code_len_24 <= l24;
      polarity_invert <= inv;
      mode_b <= inv;
      code_upper <= prog[23:12];
      code_lower <= prog[11:0];
      pattern <= {~tx[0], tx};
      pat_len <= l24 ? 5'h19 : 5'h17;
      mode <= 2'h1;
      for (int i = 0; i < max_bits * BC && !(seen && want); i++)
      begin
         @(negedge ref_clk);
         seen |= code_detected === 1'b1;
      end
      check(signal_present, 1'b1);
      check(seen, want);
      @(posedge ref_clk);
      mode <= 2'h0;
      $display("Code test done: sent %h programmed %h flag %b", tx, prog, seen);
   endtask
   task automatic run_tone(input logic en, input int want);
      int hits;
      hits = 0;
      do_reset();
      @(posedge ref_clk);
      turnoff_enable <= en;
      mode <= 2'h2;
      repeat (60 * (HMIN + HMAX) / 2)
      begin
         @(negedge ref_clk);
         hits += int'(turnoff_irq === 1'b1);
      end
      check(24'(hits), 24'(want));
      @(posedge ref_clk);
      // The host side mutes after the pulse; the decoder itself touches no audio
      mode <= 2'h0;
      $display("Tone test done: enable %b pulses %0d", en, hits);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [23:0] c;
      seed = lfsr(seed);
      c = {1'b0, seed[22:0]};
      run_code(c, c, 1'b0, 1'b0, 130);
      run_code(24'h763813, 24'h763902, 1'b0, 1'b0, 130);
      run_code(24'h763813, 24'h762902, 1'b0, 1'b0, 130);
      seed = lfsr(lfsr(seed));
      c = {1'b0, seed[30:8]};
      run_code(c, c, 1'b0, 1'b1, 130);
      seed = lfsr(lfsr(seed));
      run_code(seed[23:0], seed[23:0], 1'b1, 1'b0, 140);
      run_tone(1'b1, 1);
      run_tone(1'b0, 0);
      report_and_stop();
   end
   initial
   begin
      // Budget: every code run at its longest plus both tone runs
      repeat (4 * 130 * BC + 140 * BC + 4 * 60 * HMAX) @(posedge ref_clk);
      n_fail++;
      report_and_stop();
   end
endmodule
bind sdc_decoder sdc_decoder_asserts #(.BIT_CYCLES(BIT_CYCLES), .HALF_MIN(HALF_MIN))
   i_sdc_decoder_asserts (
      .ref_clk       (ref_clk),
      .resetn        (resetn),
      .sample_valid  (sample_valid),
      .turnoff_enable(turnoff_enable),
      .code_detected (code_detected),
      .turnoff_irq   (turnoff_irq),
      .signal_present(signal_present)
   );

/* File: sdc_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module sdc_fifo #(
   parameter int WIDTH = sdc_pkg::FIFO_WIDTH,
   parameter int DEPTH = sdc_pkg::FIFO_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output wire logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output wire logic             out_valid,
   input  wire logic             out_ready,
   output wire logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
   begin : g_bad
      $error("sdc_fifo needs a power of two depth of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;

   wire       full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire       empty = (wr_ptr == rd_ptr);
   wire       push  = in_valid && !full;
   wire       pop   = out_valid && out_ready;

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

endmodule

/* File: sdc_fm_source.sv */
// Discriminator model: sub-audio code stream, turn-off tone or idle noise.
`timescale 1ns/100ps
module sdc_fm_source #(
   parameter int BIT_CYCLES = 160,
   parameter int HALF       = 80,
   parameter int AMP        = 800
) (
   input  wire logic               ref_clk,
   input  wire logic        [1:0]  mode,
   input  wire logic        [24:0] pattern,
   input  wire logic        [4:0]  pat_len,
   input  wire logic               mode_b,
   output logic signed      [11:0] disc_sample,
   output logic                    sample_valid
);
   wire logic signed [11:0] amp = 12'(AMP);
   int                      ph  = 0;
   int                      idx = 0;
   logic                    lvl = 1'b0;
   logic                    hi;
   // Single driver: outputs stay unknown only until the first edge, well inside reset
   always @(posedge ref_clk)
   begin
      sample_valid <= 1'b1;
      ph = (mode == 2'h0) ? 0 : ph + 1;
      if (mode == 2'h0)
         idx = 0;
      // Least significant code bit goes out first, one per bit period
      if (mode == 2'h1 && ph >= BIT_CYCLES)
      begin
         ph = 0;
         idx = (idx + 1 >= int'(pat_len)) ? 0 : idx + 1;
      end
      // Idle flips every cycle so no stale level passes for a signal
      if (mode == 2'h0 || (mode == 2'h2 && ph >= HALF))
      begin
         ph = 0;
         lvl = !lvl;
      end
      hi = (mode == 2'h1) ? pattern[idx[4:0]] ^ mode_b : lvl;
      disc_sample <= (mode == 2'h0) ? (lvl ? 12'sh008 : -12'sh008) : (hi ? amp : -amp);
   end
endmodule

/* File: sdc_pkg.sv */
// Constants shared by the sub-audio digital code decoder files.
package sdc_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Clock and signalling rates
   localparam longint CLK_HZ          = 64'd10000000;
   localparam longint BIT_RATE_MBPS   = 64'd134400;
   localparam longint BIT_TOL_MBPS    = 64'd400;
   localparam longint TONE_MHZ        = 64'd134400;
   localparam longint TONE_TOL_MHZ    = 64'd500;
   localparam longint TONE_MIN_MS     = 64'd150;
   localparam longint TONE_MAX_MS     = 64'd200;

   // Nominal bit period in clock cycles
   localparam int BIT_CYCLES     = int'((CLK_HZ * 64'd1000) / BIT_RATE_MBPS);
   // Shortest and longest tone half period in clock cycles
   localparam int TONE_HALF_MIN  = int'((CLK_HZ * 64'd1000) / (64'd2 * (TONE_MHZ + TONE_TOL_MHZ)));
   localparam int TONE_HALF_MAX  = int'((CLK_HZ * 64'd1000) / (64'd2 * (TONE_MHZ - TONE_TOL_MHZ)));
   // Half periods that make up the least tone duration, rounded up
   localparam int TONE_MIN_HALVES =
      int'((TONE_MIN_MS * TONE_MHZ * 64'd2 + 64'd999999) / 64'd1000000);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Code layout and matching
   localparam int CODE_MAX_BITS  = 24;
   localparam int CODE_SHORT_BITS = 23;
   localparam int FIELD_BITS     = 12;
   localparam int MAX_ERRORS     = 3;
   localparam int FLAG_EVERY     = 4;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Front end filter shifts and buffering
   localparam int LPF_SHIFT      = 6;
   localparam int EQ_SHIFT       = 2;
   localparam int ENV_SHIFT      = 5;
   localparam int HYST_SHIFT     = 2;
   localparam int FIFO_DEPTH     = 32;
   localparam int FIFO_WIDTH     = 1;

endpackage

/* File: sdc_tone_det.sv */
// Turn-off tone detector working on slicer transition spacing.
`timescale 1ns/100ps
module sdc_tone_det #(
   parameter int HALF_MIN = sdc_pkg::TONE_HALF_MIN,
   parameter int HALF_MAX = sdc_pkg::TONE_HALF_MAX,
   parameter int HALVES   = sdc_pkg::TONE_MIN_HALVES
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic edge_seen,
   input  wire logic enable,
   output logic      tone_event
);
   localparam int CW = $clog2(HALF_MAX + 2);
   localparam int GW = $clog2(HALVES + 1);

   if (HALF_MIN < 1 || HALF_MAX < HALF_MIN || HALVES < 1)
   begin : g_bad
      $error("sdc_tone_det window or length out of range");
   end

   logic [CW-1:0] gap;
   logic [GW-1:0] good;
   logic          fired;

   wire           gap_over = (gap > CW'(HALF_MAX));
   wire           gap_ok   = (gap >= CW'(HALF_MIN)) && !gap_over;
   wire           reached  = (good == GW'(HALVES));

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         gap        <= '0;
         good       <= '0;
         fired      <= 1'b0;
         tone_event <= 1'b0;
      end
      else
      begin
         tone_event <= 1'b0;
         if (edge_seen)
         begin
            gap <= '0;
         end
         else if (!gap_over)
         begin
            gap <= gap + 1'b1;
         end
         // Any off-frequency half period or a stall breaks the run
         if ((edge_seen && !gap_ok) || gap_over)
         begin
            good  <= '0;
            fired <= 1'b0;
         end
         else if (edge_seen && !reached)
         begin
            good <= good + 1'b1;
         end
         // One event per tone burst
         if (reached && !fired && enable)
         begin
            fired      <= 1'b1;
            tone_event <= 1'b1;
         end
      end
   end

endmodule
